// [sss_status_top.sv]
// Slot and battery status register bank behind the two-wire control port.
// Assumes SCL and SDA_IN are already synchronous to CLK_SYS; SDA is open drain.
// Contract
// RULE1 - Status bit 0 shows the sampled shutdown input level.
// RULE2 - Status bit 1 is a shutdown interrupt flag, cleared by reading.
// RULE3 - Status bit 2 is 1 once battery absence survives debounce.
// RULE4 - Status bit 3 is a battery-removal interrupt flag, cleared by reading.
// RULE5 - Bits 5:4 carry the slot one status code.
// RULE6 - Bits 7:6 carry the slot two status code, same scheme.
// RULE7 - Slot status comes from written state bits and regulator enable.
// RULE8 - Regulator off with state 00 or 01 reports 00.
// RULE9 - Regulator off with state 11 reports 00.
// RULE10 - Regulator on with state 00 reports 10.
// RULE11 - Regulator on reports 01 for 01 and 11 for 11.
// RULE12 - Host never writes state code 10.
// RULE13 - Written code 10 reports 10 when powered, 00 when not.
// RULE14 - Regulator enable 0 turns off and pulls down; 1 powers and releases.
// RULE15 - Debounce value 00h makes battery status follow input directly.
// RULE16 - Writes to the status address change nothing.
`timescale 1ns/100ps
module sss_status_top #(
    parameter logic [6:0] DEV_ADDR = sss_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic SLOT_TWO_SHUTDOWN_INPUT,
    input wire logic BATTERY_PRESENCE_INPUT,
    output logic [sss_pkg::SLOTS-1:0] REG_EN,
    output logic [sss_pkg::SLOTS-1:0] REG_PULLDOWN
);
    import sss_pkg::*;

    sss_i2c_state_e state_reg;
    sss_i2c_state_e after_ack_reg;
    logic scl_q, sda_q, scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] shift_reg, rx_byte, tx_reg, ptr_reg, rd_data;
    logic [2:0] bit_cnt_reg;
    logic byte_done_reg;
    logic wr_stb, rd_clr;
    logic [7:0] ctrl_reg, batt_dbc_reg, status;
    logic shdn_lvl_reg, shdn_irq_reg, shdn_evt;
    logic batt_absent_reg, batt_irq_reg, batt_next, batt_evt;
    logic [7:0] dbc_cnt_reg;
    logic [8:0] div_reg;
    logic tick;
    logic [1:0] slot_status [SLOTS];

    // ==========================================================
    // Bus line edges
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= SCL;
            sda_q <= SDA_IN;
        end
    end

    assign scl_rise = SCL && !scl_q;
    assign scl_fall = !SCL && scl_q;
    assign start_cond = SCL && scl_q && sda_q && !SDA_IN;
    assign stop_cond = SCL && scl_q && !sda_q && SDA_IN;
    assign rx_byte = {shift_reg[6:0], SDA_IN};

    // ==========================================================
    // Two-wire slave sequencer
    // Pointer does not auto-increment, so repeated reads poll one register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_reg <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= PTR_RST;
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (start_cond) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            SDA_OE <= 1'b0;
        end else if (scl_rise) begin
            if (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WR) begin
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    byte_done_reg <= 1'b1;
                end
            end else if (state_reg == ST_RACK) begin
                // Master NACK ends the read burst
                if (SDA_IN) begin
                    state_reg <= ST_IDLE;
                end else begin
                    byte_done_reg <= 1'b1;
                end
            end
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done_reg) begin
                        byte_done_reg <= 1'b0;
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            SDA_OE <= 1'b1;
                            state_reg <= ST_ACK;
                            after_ack_reg <= shift_reg[0] ? ST_RD : ST_PTR;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_PTR, ST_WR: begin
                    if (byte_done_reg) begin
                        byte_done_reg <= 1'b0;
                        SDA_OE <= 1'b1;
                        state_reg <= ST_ACK;
                        after_ack_reg <= ST_WR;
                        if (state_reg == ST_PTR) begin
                            ptr_reg <= shift_reg;
                        end
                    end
                end
                ST_ACK: begin
                    bit_cnt_reg <= 3'h0;
                    state_reg <= after_ack_reg;
                    SDA_OE <= 1'b0;
                    if (after_ack_reg == ST_RD) begin
                        tx_reg <= rd_data;
                        SDA_OE <= !rd_data[7];
                        bit_cnt_reg <= 3'h1;
                    end
                end
                ST_RD: begin
                    if (bit_cnt_reg == 3'h0) begin
                        SDA_OE <= 1'b0;
                        state_reg <= ST_RACK;
                    end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        SDA_OE <= !tx_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                ST_RACK: begin
                    if (byte_done_reg) begin
                        byte_done_reg <= 1'b0;
                        tx_reg <= rd_data;
                        SDA_OE <= !rd_data[7];
                        bit_cnt_reg <= 3'h1;
                        state_reg <= ST_RD;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge CLK_SYS) begin
        SDA_OUT <= 1'b0;
    end

    // ==========================================================
    // Register access strobes
    // A byte is loaded for transmit when an ack slot hands over to read
    assign wr_stb = scl_fall && !start_cond && !stop_cond && state_reg == ST_WR
        && byte_done_reg;
    assign rd_clr = scl_fall && !start_cond && !stop_cond && ptr_reg == ADDR_STATUS
        && ((state_reg == ST_ACK && after_ack_reg == ST_RD)
        || (state_reg == ST_RACK && byte_done_reg));

    // Read mux; unmapped addresses read zero
    always_comb begin
        if (ptr_reg == ADDR_STATUS) begin
            rd_data = status;
        end else if (ptr_reg == ADDR_CTRL) begin
            rd_data = ctrl_reg;
        end else if (ptr_reg == ADDR_BATT_DBC) begin
            rd_data = batt_dbc_reg;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Writable registers; the status address has no write path
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            ctrl_reg <= CTRL_RST;
            batt_dbc_reg <= BATT_DBC_RST;
        end else if (wr_stb) begin
            if (ptr_reg == ADDR_CTRL) begin
                ctrl_reg <= shift_reg;
            end else if (ptr_reg == ADDR_BATT_DBC) begin
                batt_dbc_reg <= shift_reg;
            end
        end
    end // RULE16

    // ==========================================================
    // Regulator drive
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            REG_EN <= '0;
            REG_PULLDOWN <= '1;
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                REG_EN[i] <= ctrl_reg[CTRL_SLOT_STRIDE*i]; // RULE14
                REG_PULLDOWN[i] <= !ctrl_reg[CTRL_SLOT_STRIDE*i]; // RULE14
            end
        end
    end

    // ==========================================================
    // Shutdown input and its flag; set beats the read clear
    assign shdn_evt = SLOT_TWO_SHUTDOWN_INPUT != shdn_lvl_reg;
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            shdn_lvl_reg <= 1'b0;
            shdn_irq_reg <= 1'b0;
        end else begin
            shdn_lvl_reg <= SLOT_TWO_SHUTDOWN_INPUT; // RULE1
            if (shdn_evt) begin
                shdn_irq_reg <= 1'b1; // RULE2
            end else if (rd_clr) begin
                shdn_irq_reg <= 1'b0; // RULE2
            end
        end
    end

    // ==========================================================
    // 32 kHz tick divider
    assign tick = div_reg == TICK_LAST;
    always_ff @(posedge CLK_SYS) begin
        if (SRST || tick) begin
            div_reg <= 9'h000;
        end else begin
            div_reg <= div_reg + 9'h001;
        end
    end

    // ==========================================================
    // Battery presence debounce; input high means battery absent
    // A new count value restarts any debounce in progress
    always_comb begin
        batt_next = batt_absent_reg;
        if (batt_dbc_reg == 8'h00) begin
            batt_next = BATTERY_PRESENCE_INPUT; // RULE15
        end else if (tick && BATTERY_PRESENCE_INPUT != batt_absent_reg
            && dbc_cnt_reg + 8'h01 >= batt_dbc_reg) begin
            batt_next = BATTERY_PRESENCE_INPUT; // RULE3
        end
    end
    assign batt_evt = batt_next && !batt_absent_reg;

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            dbc_cnt_reg <= 8'h00;
            batt_absent_reg <= 1'b0;
        end else begin
            batt_absent_reg <= batt_next;
            if (BATTERY_PRESENCE_INPUT == batt_absent_reg || batt_next != batt_absent_reg
                || (wr_stb && ptr_reg == ADDR_BATT_DBC)) begin
                dbc_cnt_reg <= 8'h00;
            end else if (tick) begin
                dbc_cnt_reg <= dbc_cnt_reg + 8'h01;
            end
        end
    end

    // Removal flag, set wins over read clear
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            batt_irq_reg <= 1'b0;
        end else if (batt_evt) begin
            batt_irq_reg <= 1'b1; // RULE4
        end else if (rd_clr) begin
            batt_irq_reg <= 1'b0; // RULE4
        end
    end

    // ==========================================================
    // Slot status mapping, one per slot
    // Code 10 is not blocked; host is trusted to avoid it
    for (genvar g = 0; g < SLOTS; g++) begin : g_slot
        sss_slot_map u_map (
            .state_code(ctrl_reg[CTRL_SLOT_STRIDE*g+CTRL_STATE_OFS +: 2]), // RULE7 RULE12
            .reg_en(ctrl_reg[CTRL_SLOT_STRIDE*g]), // RULE7
            .status_code(slot_status[g])
        );
    end

    assign status = {slot_status[1], slot_status[0], batt_irq_reg, batt_absent_reg,
        shdn_irq_reg, shdn_lvl_reg}; // RULE5 RULE6

    // ==========================================================
    // Checks
    sequence s_batt_read;
        rd_clr && !batt_evt;
    endsequence

    a_shdn_level_sample: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE1
        ##1 status[STAT_SHDN_LVL] == $past(SLOT_TWO_SHUTDOWN_INPUT))
        else $error("shutdown level not sampled");
    a_shdn_irq_set: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE2
        shdn_evt |=> status[STAT_SHDN_IRQ])
        else $error("shutdown flag not set");
    a_shdn_irq_clear: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE2
        rd_clr && !shdn_evt |=> !status[STAT_SHDN_IRQ])
        else $error("shutdown flag not cleared by read");
    a_batt_irq_set: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE4
        $rose(status[STAT_BATT]) |-> status[STAT_BATT_IRQ])
        else $error("removal flag missing");
    a_batt_irq_clear: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE4
        s_batt_read |=> !status[STAT_BATT_IRQ])
        else $error("removal flag not cleared by read");
    a_batt_no_debounce: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE15
        batt_dbc_reg == 8'h00 |=> status[STAT_BATT] == $past(BATTERY_PRESENCE_INPUT))
        else $error("battery status lags with debounce off");
    a_batt_hold_tick: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE3
        batt_dbc_reg != 8'h00 && !tick |=> $stable(status[STAT_BATT]))
        else $error("battery status moved between ticks");
    a_slot_off_down: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE8 RULE9
        !ctrl_reg[0] |-> status[STAT_SLOT_BASE +: 2] == SLOT_DOWN)
        else $error("unpowered slot one not down");
    a_slot_on_powered: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE10
        ctrl_reg[4] && ctrl_reg[7:6] == SLOT_DOWN |-> status[7:6] == SLOT_POWERED)
        else $error("powered slot two wrong");
    a_slot_on_follow: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE11 RULE13
        ctrl_reg[0] && ctrl_reg[3:2] != SLOT_DOWN |-> status[5:4] == ctrl_reg[3:2])
        else $error("slot one status mismatch");
    a_status_wr_none: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE16
        wr_stb && ptr_reg == ADDR_STATUS && status[STAT_SHDN_IRQ] |=> status[STAT_SHDN_IRQ])
        else $error("write to status changed a flag");
    a_reg_pulldown: assert property (@(posedge CLK_SYS) disable iff (SRST) // RULE14
        ##1 REG_PULLDOWN[1] == !$past(ctrl_reg[4]) && REG_EN[1] == $past(ctrl_reg[4]))
        else $error("regulator drive wrong");

endmodule

// [sss_pkg.sv]
// Shared constants for the slot and battery status block.
// Assumes a 10 MHz system clock and the two-wire control port of the device.
package sss_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_BATT_DBC = 8'h0A;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BATT_DBC_RST = 8'h04;
    localparam logic [7:0] PTR_RST = 8'h00;

    // ==========================================================
    // Field positions
    localparam int STAT_SHDN_LVL = 0;
    localparam int STAT_SHDN_IRQ = 1;
    localparam int STAT_BATT = 2;
    localparam int STAT_BATT_IRQ = 3;
    localparam int STAT_SLOT_BASE = 4;
    localparam int CTRL_SLOT_STRIDE = 4;
    localparam int CTRL_STATE_OFS = 2;
    localparam int SLOTS = 2;

    // ==========================================================
    // Slot status codes
    localparam logic [1:0] SLOT_DOWN = 2'h0;
    localparam logic [1:0] SLOT_POWERED = 2'h2;

    // ==========================================================
    // Timing: 32 kHz tick derived from the system clock
    localparam int CLK_HZ = 10000000;
    localparam int TICK_HZ = 32768;
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [8:0] TICK_LAST = 9'(TICK_DIV - 1);

    // ==========================================================
    // Two-wire port
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // Arbitrary value

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WR,
        ST_ACK,
        ST_RD,
        ST_RACK
    } sss_i2c_state_e;

endpackage

// [sss_slot_map.sv]
// Maps one slot's written state code and regulator enable to its status code.
// Assumes the caller registers or samples the result; purely combinational.
`timescale 1ns/100ps
module sss_slot_map (
    input wire logic [1:0] state_code,
    input wire logic reg_en,
    output logic [1:0] status_code
);
    import sss_pkg::*;

    // ==========================================================
    // Mapping
    // Unpowered slot can be neither isolated nor active
    always_comb begin
        if (!reg_en) begin
            status_code = SLOT_DOWN; // RULE8 RULE9
        end else if (state_code == SLOT_DOWN) begin
            status_code = SLOT_POWERED; // RULE10
        end else begin
            // Forbidden code 10 falls through as powered with pull-downs released
            status_code = state_code; // RULE11 RULE13
        end
    end

endmodule

// [sss_host_model.sv]
// Two-wire host model standing in for the baseband processor.
// Assumes a pulled-up open-drain SDA; SCL phases last three system clocks.
`timescale 1ns/100ps
module sss_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic CLK_SYS,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    output logic SCL,
    output logic SDA_IN
);
    logic sda_drv = 1'b1;
    initial SCL = 1'b1;

    // ==========================================================
    // Wire
    // Wired-AND: the pull-up wins only when nobody pulls low
    assign SDA_IN = sda_drv & ~(SDA_OE & ~SDA_OUT);

    // ==========================================================
    // Bit level
    // Three clocks per phase keeps the two-clock minimum with margin
    task automatic half();
        repeat (3) @(posedge CLK_SYS);
        #10;
    endtask

    // Data set while SCL low, sampled just before SCL falls
    task automatic bit_io(input logic b, output logic seen);
        sda_drv = b;
        half();
        SCL = 1'b1;
        half();
        seen = SDA_IN;
        SCL = 1'b0;
    endtask

    // Also serves as repeated start when SCL is low
    task automatic start();
        sda_drv = 1'b1;
        half();
        SCL = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        SCL = 1'b0;
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        half();
        SCL = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask

    // One byte MSB first, then the ninth bit; ack is the device's pull
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, a);
        ack = ~a;
    endtask

    // ==========================================================
    // Register access
    // Software never stores slot state 10; only a bench scenario asks for it
    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({DEV_ADDR, 1'b0}, rx, a0);
        xfer(ptr, rx, a1);
        xfer(data, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Single byte read closed by a NACK, so the flags clear only once
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, nk;
        start();
        xfer({DEV_ADDR, 1'b0}, rx, a0);
        xfer(ptr, rx, a1);
        start();
        xfer({DEV_ADDR, 1'b1}, rx, a2);
        xfer(8'hFF, data, nk);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// [sss_status_top_tb_top.sv]
// Self-checking bench for the slot and battery status register bank.
// Assumes the host model file is compiled first; the clock runs at 10 MHz.
`timescale 1ns/100ps
module sss_status_top_tb_top;
    import sss_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic shdn_in = 1'b0;
    logic batt_in = 1'b0;
    logic scl, sda_in, sda_out, sda_oe, ok, shdn_v, sf;
    logic [1:0] reg_en, reg_pd;
    logic [7:0] ctrl_v = CTRL_RST;
    logic [7:0] rd;
    logic [31:0] seed = 32'h8147;
    int bad_count = 0;
    int samples_checked = 0;

    sss_status_top #(.DEV_ADDR(DEV_ADDR_DEFAULT)) uut (.CLK_SYS(clk_sys), .SRST(srst),
        .SCL(scl), .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .SLOT_TWO_SHUTDOWN_INPUT(shdn_in), .BATTERY_PRESENCE_INPUT(batt_in),
        .REG_EN(reg_en), .REG_PULLDOWN(reg_pd));
    sss_host_model #(.DEV_ADDR(DEV_ADDR_DEFAULT)) host (.CLK_SYS(clk_sys), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .SCL(scl), .SDA_IN(sda_in));

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // A hung transfer ends the run as a failure
    initial begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        summarize();
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Slot status: off reports down, state 00 powered reports 10
    function automatic logic [1:0] slot_exp(input logic [1:0] code, input logic en);
        return en ? ((code == 2'h0) ? 2'h2 : code) : 2'h0;
    endfunction

    function automatic logic [7:0] stat_exp(input logic [7:0] c, input logic shdn, input logic sfl,
                                            input logic bat, input logic bfl);
        return {slot_exp(c[7:6], c[4]), slot_exp(c[3:2], c[0]), bfl, bat, sfl, shdn};
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        host.write_reg(ptr, data, ok);
        check("write ack", {7'h0, ok}, 8'h01);
    endtask

    task automatic stat(input logic [7:0] exp);
        host.read_reg(ADDR_STATUS, rd, ok);
        check("read ack", {7'h0, ok}, 8'h01);
        check("status", rd, exp);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        shdn_v = 1'b0;
        repeat (20) @(posedge clk_sys);
        #10;
        srst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #10;
        stat(8'h00);
        check("reg_pulldown", {6'h0, reg_pd}, 8'h03);
        $display("test reset done");

        // Every state code against both enables, voltage select bits random
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            ctrl_v = {i[3:2], seed[5], i[4], i[1:0], seed[1], i[2]};
            wr(ADDR_CTRL, ctrl_v);
            check("reg_en", {6'h0, reg_en}, {6'h0, ctrl_v[4], ctrl_v[0]});
            check("reg_pulldown", {6'h0, reg_pd}, {6'h0, ~ctrl_v[4], ~ctrl_v[0]});
            host.read_reg(ADDR_CTRL, rd, ok);
            check("ctrl readback", rd, ctrl_v);
            sf = (seed[9] != shdn_v);
            shdn_v = seed[9];
            shdn_in = shdn_v;
            wr(ADDR_STATUS, seed[23:16]);
            stat(stat_exp(ctrl_v, shdn_v, sf, 1'b0, 1'b0));
        end
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b0, 1'b0));
        $display("test slot mapping done");

        // Removal must outlast the default debounce before it shows
        batt_in = 1'b1;
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b0, 1'b0));
        repeat (1400) @(posedge clk_sys);
        #10;
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b1, 1'b1));
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b1, 1'b0));
        // Debounce off: the pin shows through at once
        wr(ADDR_BATT_DBC, 8'h00);
        batt_in = 1'b0;
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b0, 1'b0));
        batt_in = 1'b1;
        stat(stat_exp(ctrl_v, shdn_v, 1'b0, 1'b1, 1'b1));
        $display("test battery done");
        summarize();
    end
endmodule
